// ==== shared/dpsc_defines.vh ====
// dpsc_defines.vh: timing counts and pin-level constants for the dual-port sram port controller
// assumes a 20 MHz system clock; all times are in ns and DPSC_CYC_UP turns them into clk_sys cycles
// How it works
// [RULE_01] array: cs low, byte low, flag high
// [RULE_02] device writes during cs, strobe, byte overlap
// [RULE_03] host changes address only with strobe high
// [RULE_04] late cs or flag select keeps outputs off
// [RULE_05] pulse covers turnoff plus setup when drive low
// [RULE_06] host drives data only after device release
// [RULE_07] flag read repeats value on every line
// [RULE_08] flag write then read with array off
// [RULE_09] wait 5 ns between flag write and read
// [RULE_10] flag writes within 5 ns: winner unsure
// [RULE_11] device drives only while all selects low
// [RULE_12] cross-port read valid after port delay
// [RULE_13] write ends at first rising strobe or select
// [RULE_14] flag write value taken from bit zero
// [RULE_15] upper select nine high bits, lower nine low
`ifndef DPSC_DEFINES_VH
`define DPSC_DEFINES_VH

`define DPSC_CLK_PERIOD_NS   50
`define DPSC_DATA_W          18
`define DPSC_ADDR_W          13
// minimum write pulse, turnoff and setup times in ns
`define DPSC_T_PULSE_NS      15
`define DPSC_T_OFF_NS        12
`define DPSC_T_SETUP_NS      15
`define DPSC_T_ACCESS_NS     20
`define DPSC_T_FLAG_WR_RD_NS 5
`define DPSC_T_PORT_DLY_NS   45
// least times round up to whole cycles, never below one
`define DPSC_CYC_UP(ns) ((((ns) + `DPSC_CLK_PERIOD_NS - 1) / `DPSC_CLK_PERIOD_NS) > 0 ? \
    (((ns) + `DPSC_CLK_PERIOD_NS - 1) / `DPSC_CLK_PERIOD_NS) : 1)
`define DPSC_OP_READ         2'h0
`define DPSC_OP_WRITE        2'h1
`define DPSC_OP_FLAG_WRITE   2'h2
`define DPSC_OP_FLAG_READ    2'h3

`endif

// ==== hdl/dpsc_wait_timer.v ====
// dpsc_wait_timer.v: loadable down counter that flags when a wait has elapsed
// assumes load and load_value come from the port controller on the same clock
`timescale 1ns/10ps
module dpsc_wait_timer #(
    parameter W = 4
) (
    input  wire         clk_sys,
    input  wire         rst_n,
    input  wire         load,
    input  wire [W-1:0] load_value,
    output wire         done
);
    reg [W-1:0] count;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= {W{1'b0}};
        end else if (load) begin
            count <= load_value;
        end else if (count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end

    // done looks only at the count, never at load, so a caller may reload straight from done
    // without closing a combinational path through this module
    assign done = (count == {W{1'b0}});
endmodule // dpsc_wait_timer

// ==== hdl/dpsc_port_ctrl.v ====
// dpsc_port_ctrl.v: host-side controller driving one port of an asynchronous dual-port sram
// assumes user requests and sram inputs are synchronous to clk_sys; the shared data pins are
// split into in, out and enable, resolved outside this module
`timescale 1ns/10ps
`include "dpsc_defines.vh"
module dpsc_port_ctrl #(
    parameter DATA_W = `DPSC_DATA_W,
    parameter ADDR_W = `DPSC_ADDR_W
) (
    input  wire              clk_sys,
    input  wire              rst_n,
    input  wire              req_valid,
    output wire              req_ready,
    input  wire [1:0]        req_op,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire [DATA_W-1:0] req_wdata,
    input  wire [1:0]        req_byte_en,
    output reg               rsp_valid,
    output reg  [DATA_W-1:0] rsp_rdata,
    output reg               chip_select_n,
    output reg               write_strobe_n,
    output reg               output_drive_n,
    output reg               upper_byte_select_n,
    output reg               lower_byte_select_n,
    output reg               flag_space_select_n,
    output reg  [ADDR_W-1:0] addr,
    output reg  [DATA_W-1:0] data_out,
    output reg               data_oe,
    input  wire [DATA_W-1:0] data_in
);
    localparam LANES = 2;
    localparam HALF_W = DATA_W / LANES;
    localparam TW = 4;
    // waits are worked out as integers and cut to the timer width on purpose;
    // anything past fifteen cycles would need a wider timer
    localparam integer PULSE_I     = `DPSC_CYC_UP(`DPSC_T_PULSE_NS);
    localparam integer OFF_SETUP_I = `DPSC_CYC_UP(`DPSC_T_OFF_NS + `DPSC_T_SETUP_NS);
    localparam integer WR_I        = (PULSE_I > OFF_SETUP_I) ? PULSE_I : OFF_SETUP_I;
    localparam integer ACCESS_I    = `DPSC_CYC_UP(`DPSC_T_ACCESS_NS);
    localparam integer FLAG_GAP_I  = `DPSC_CYC_UP(`DPSC_T_FLAG_WR_RD_NS);
    localparam integer PORT_DLY_I  = `DPSC_CYC_UP(`DPSC_T_PORT_DLY_NS);
    localparam [TW-1:0] CYC_WR       = WR_I[TW-1:0];
    localparam [TW-1:0] CYC_ACCESS   = ACCESS_I[TW-1:0];
    localparam [TW-1:0] CYC_FLAG_GAP = FLAG_GAP_I[TW-1:0];
    localparam [TW-1:0] CYC_PORT_DLY = PORT_DLY_I[TW-1:0];

    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_SETUP = 6'h02;
    localparam [5:0] ST_WRITE = 6'h04;
    localparam [5:0] ST_READ  = 6'h08;
    localparam [5:0] ST_END   = 6'h10;
    localparam [5:0] ST_GAP   = 6'h20;

    reg  [5:0]  state;
    reg  [1:0]  op;
    reg         t_load;
    reg  [TW-1:0] t_value;
    wire        t_done;
    wire              is_write;
    wire              is_flag;
    wire              lanes_none;
    wire [LANES-1:0]  lane_sel_n;
    wire [DATA_W-1:0] lane_wdata;
    genvar            lane;

    assign is_write = (op == `DPSC_OP_WRITE) || (op == `DPSC_OP_FLAG_WRITE);
    assign is_flag = op[1];
    // an array request with no lane enabled keeps chip select high: the array may only be
    // selected with a byte select low, so such a request completes without touching the sram
    assign lanes_none = ~|req_byte_en; // see [RULE_01]

    // each lane owns its select and its nine data bits; an unselected lane carries zeros
    // so the idle half of the bus does not toggle
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            assign lane_sel_n[lane] = ~req_byte_en[lane]; // see [RULE_15]
            assign lane_wdata[lane*HALF_W +: HALF_W] = req_byte_en[lane] ?
                req_wdata[lane*HALF_W +: HALF_W] : {HALF_W{1'b0}};
        end
    endgenerate

    dpsc_wait_timer #(
        .W          (TW)
    ) u_timer (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .load       (t_load),
        .load_value (t_value),
        .done       (t_done)
    );

    // ready is decoded straight from the state so a waiting request is taken on the first idle edge
    assign req_ready = (state == ST_IDLE);

    always @* begin
        t_load = 1'b0;
        t_value = CYC_ACCESS;
        case (state)
            ST_IDLE: begin
                // two settle cycles after the selects fall, before strobe or output drive
                t_load = req_valid;
                t_value = {{(TW-1){1'b0}}, 1'b1};
            end
            // output drive is held high during writes, so the plain pulse would do; the longer
            // figure is kept anyway so a slow turnoff never collides with our data
            ST_SETUP: begin
                t_load = t_done;
                t_value = is_write ? CYC_WR : CYC_ACCESS; // see [RULE_05]
            end
            ST_WRITE: begin
                t_load = t_done;
                t_value = CYC_FLAG_GAP; // see [RULE_09]
            end
            ST_READ: begin
                t_load = t_done;
                t_value = CYC_PORT_DLY; // see [RULE_12]
            end
            ST_END: begin
                t_load = 1'b0;
            end
            ST_GAP: begin
                t_load = 1'b0;
            end
            default: begin
                t_load = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            op <= `DPSC_OP_READ;
            rsp_valid <= 1'b0;
            rsp_rdata <= {DATA_W{1'b0}};
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            upper_byte_select_n <= 1'b1;
            lower_byte_select_n <= 1'b1;
            flag_space_select_n <= 1'b1;
            addr <= {ADDR_W{1'b0}};
            data_out <= {DATA_W{1'b0}};
            data_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        // address changes only here, with every select and strobe high
                        op <= req_op;
                        addr <= req_addr; // see [RULE_03]
                        if (req_op[1]) begin
                            // flag value goes out on every line; the device takes it from bit zero
                            chip_select_n <= 1'b1; // see [RULE_08]
                            upper_byte_select_n <= 1'b1;
                            lower_byte_select_n <= 1'b1;
                            flag_space_select_n <= 1'b0; // see [RULE_01]
                            data_out <= {DATA_W{req_wdata[0]}}; // see [RULE_14]
                        end else begin
                            chip_select_n <= lanes_none; // see [RULE_01]
                            upper_byte_select_n <= lane_sel_n[1]; // see [RULE_15]
                            lower_byte_select_n <= lane_sel_n[0];
                            flag_space_select_n <= 1'b1;
                            data_out <= lane_wdata;
                        end
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (t_done) begin
                        if (is_write) begin
                            // selects were low two cycles before the strobe and output drive
                            // stays high, so the device never drives the shared lines
                            write_strobe_n <= 1'b0; // see [RULE_02]
                            data_oe <= 1'b1; // see [RULE_06]
                            state <= ST_WRITE;
                        end else begin
                            output_drive_n <= 1'b0; // see [RULE_11]
                            state <= ST_READ;
                        end
                    end
                end
                ST_WRITE: begin
                    if (t_done) begin
                        // strobe rises first and ends the write; data held one more cycle
                        write_strobe_n <= 1'b1; // see [RULE_13]
                        state <= ST_END;
                    end
                end
                ST_READ: begin
                    if (t_done) begin
                        // flag reads come back on every line; report bit zero replicated
                        rsp_rdata <= is_flag ? {DATA_W{data_in[0]}} : data_in; // see [RULE_07]
                        output_drive_n <= 1'b1; // see [RULE_11]
                        state <= ST_END;
                    end
                end
                ST_END: begin
                    // write data stays driven one cycle past the strobe rise, covering hold time
                    data_oe <= 1'b0;
                    chip_select_n <= 1'b1;
                    upper_byte_select_n <= 1'b1;
                    lower_byte_select_n <= 1'b1;
                    flag_space_select_n <= 1'b1;
                    rsp_valid <= 1'b1;
                    state <= ST_GAP;
                end
                // after a flag write the gap covers the write-to-read wait; contention with the
                // other port inside its window is the device's concern, this port never retries
                ST_GAP: begin
                    if (t_done) begin
                        state <= ST_IDLE; // see [RULE_10]
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // dpsc_port_ctrl

// ==== tb/dpsc_port_ctrl_props.sv ====
// dpsc_port_ctrl_props.sv: pin-level checks on the host side of the sram port
// assumes sram pins are registered on clk_sys
`timescale 1ns/10ps
module dpsc_port_ctrl_props (
    input wire        clk_sys,
    input wire        rst_n,
    input wire        chip_select_n,
    input wire        write_strobe_n,
    input wire        output_drive_n,
    input wire        upper_byte_select_n,
    input wire        lower_byte_select_n,
    input wire        flag_space_select_n,
    input wire [12:0] addr,
    input wire [17:0] data_out,
    input wire        data_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire both_off = upper_byte_select_n && lower_byte_select_n;
    sequence s_pulse; !write_strobe_n ##1 !write_strobe_n; endsequence
    sequence s_quiet; output_drive_n ##1 output_drive_n; endsequence
    property p_addr_quiet; !$stable(addr) |-> write_strobe_n || chip_select_n || both_off; endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("address moved in write");
    property p_array; !chip_select_n |-> flag_space_select_n && !both_off; endproperty
    a_array: assert property (p_array) else $error("bad array select");
    property p_flag_apart; !flag_space_select_n |-> chip_select_n || both_off; endproperty
    a_flag_apart: assert property (p_flag_apart) else $error("array selected in flag op");
    property p_pulse; $fell(write_strobe_n) |-> s_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse short");
    property p_data_held; !write_strobe_n |-> data_oe && $stable(data_out); endproperty
    a_data_held: assert property (p_data_held) else $error("data not held in pulse");
    property p_release; data_oe |-> output_drive_n && $past(output_drive_n); endproperty
    a_release: assert property (p_release) else $error("host drove too early");
    property p_no_fight; !output_drive_n |-> write_strobe_n && !data_oe; endproperty
    a_no_fight: assert property (p_no_fight) else $error("drive overlaps write");
    property p_flag_gap; $rose(write_strobe_n) |-> s_quiet; endproperty
    a_flag_gap: assert property (p_flag_gap) else $error("read too soon after write");
endmodule // dpsc_port_ctrl_props
bind dpsc_port_ctrl dpsc_port_ctrl_props u_props (.clk_sys, .rst_n, .chip_select_n, .write_strobe_n,
    .output_drive_n, .upper_byte_select_n, .lower_byte_select_n, .flag_space_select_n, .addr, .data_out, .data_oe);

// ==== tb/dpsc_sram_model.sv ====
// dpsc_sram_model.sv: behavioural sram port with one flag, resolving the shared data lines
// assumes host pins change only just after clk_sys edges
`timescale 1ns/10ps
module dpsc_sram_model (
    input  wire        clk_sys,
    input  wire        chip_select_n,
    input  wire        write_strobe_n,
    input  wire        output_drive_n,
    input  wire        upper_byte_select_n,
    input  wire        lower_byte_select_n,
    input  wire        flag_space_select_n,
    input  wire [12:0] addr,
    input  wire [17:0] data_out,
    input  wire        data_oe,
    output wire [17:0] data_in
);
    reg  [17:0] mem [0:8191];
    reg  [17:0] last = 18'h00000;
    reg         flag = 1'b0;
    wire        arr = !chip_select_n && flag_space_select_n && !(upper_byte_select_n && lower_byte_select_n);
    wire        flag_acc = !flag_space_select_n && !arr;
    // strobe low keeps outputs off whatever drive says
    wire        drv = !output_drive_n && write_strobe_n && (arr || flag_acc);
    wire [17:0] en = flag_acc ? 18'h3FFFF : {{9{!upper_byte_select_n}}, {9{!lower_byte_select_n}}};
    wire [17:0] q = flag_acc ? {18{flag}} : mem[addr];
    // released lines show the inverse of their last level so stale data cannot pass
    assign data_in = data_oe ? data_out : drv ? (q & en) | (~last & ~en) : ~last;
    always @(posedge clk_sys) begin
        last <= data_in;
        // array writes last only while strobe, chip select and at least one byte select overlap; a rising strobe ends them
        // only this port is modelled: new data is readable at once and a lone writer always wins the flag
        if (!write_strobe_n && arr)
            mem[addr] <= (data_in & en) | (mem[addr] & ~en);
        if (!write_strobe_n && flag_acc)
            flag <= data_in[0];
    end
endmodule // dpsc_sram_model

// ==== tb/dpsc_port_ctrl_test.sv ====
// dpsc_port_ctrl_test.sv: self-checking bench for the sram port controller
// assumes the sram model and the bound checker are compiled alongside
`timescale 1ns/10ps
module dpsc_port_ctrl_test;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg         req_valid = 1'b0;
    reg  [1:0]  req_op = 2'h0;
    reg  [12:0] req_addr = 13'h0000;
    reg  [17:0] req_wdata = 18'h00000;
    reg  [1:0]  req_byte_en = 2'h0;
    reg  [17:0] rd;
    wire        req_ready, rsp_valid, chip_select_n, write_strobe_n, output_drive_n, data_oe;
    wire        upper_byte_select_n, lower_byte_select_n, flag_space_select_n;
    wire [12:0] addr;
    wire [17:0] rsp_rdata, data_out, data_in;
    integer     fail_count = 0, checked = 0, cycles = 0;
    dpsc_port_ctrl uut (.clk_sys, .rst_n, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata, .req_byte_en,
        .rsp_valid, .rsp_rdata, .chip_select_n, .write_strobe_n, .output_drive_n, .upper_byte_select_n,
        .lower_byte_select_n, .flag_space_select_n, .addr, .data_out, .data_oe, .data_in);
    dpsc_sram_model u_sram (.clk_sys, .chip_select_n, .write_strobe_n, .output_drive_n, .upper_byte_select_n,
        .lower_byte_select_n, .flag_space_select_n, .addr, .data_out, .data_oe, .data_in);
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            stop_test;
        end
    end
    task stop_test;
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task check(input [17:0] seen, input [17:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // request held until taken, then result read once the completion pulse is seen
    task do_op(input [1:0] op, input [12:0] a, input [17:0] d, input [1:0] be);
        integer n;
        begin
            @(posedge clk_sys);
            req_valid <= 1'b1;
            req_op <= op;
            req_addr <= a;
            req_wdata <= d;
            req_byte_en <= be;
            @(negedge clk_sys);
            for (n = 0; req_ready !== 1'b1 && n < 20; n = n + 1) @(negedge clk_sys);
            @(posedge clk_sys);
            req_valid <= 1'b0;
            @(negedge clk_sys);
            for (n = 0; rsp_valid !== 1'b1 && n < 20; n = n + 1) @(negedge clk_sys);
            check({17'h00000, rsp_valid}, 18'h00001);
            rd = rsp_rdata;
        end
    endtask
    task t_idle;
        check({11'h000, chip_select_n, write_strobe_n, output_drive_n, upper_byte_select_n,
            lower_byte_select_n, flag_space_select_n, data_oe}, 18'h0007E);
    endtask
    task t_lanes;
        begin
            do_op(2'h1, 13'h1FFF, 18'h3FFFF, 2'h3);
            do_op(2'h1, 13'h0000, 18'h15555, 2'h3);
            do_op(2'h1, 13'h1FFF, 18'h00000, 2'h1);
            do_op(2'h0, 13'h1FFF, 18'h00000, 2'h3);
            check(rd, 18'h3FE00);
            do_op(2'h0, 13'h0000, 18'h00000, 2'h3);
            check(rd, 18'h15555);
            do_op(2'h1, 13'h1FFF, 18'h2AAAA, 2'h2);
            do_op(2'h0, 13'h1FFF, 18'h00000, 2'h3);
            check(rd, 18'h2AA00);
            // a write with no lane enabled must leave the word alone
            do_op(2'h1, 13'h1FFF, 18'h3FFFF, 2'h0);
            do_op(2'h0, 13'h1FFF, 18'h00000, 2'h3);
            check(rd, 18'h2AA00);
        end
    endtask
    task t_flag;
        begin
            do_op(2'h2, 13'h0003, 18'h00001, 2'h0);
            do_op(2'h3, 13'h0003, 18'h00000, 2'h0);
            check(rd, 18'h3FFFF);
            do_op(2'h2, 13'h0003, 18'h3FFFE, 2'h0);
            do_op(2'h3, 13'h0003, 18'h3FFFF, 2'h0);
            check(rd, 18'h00000);
            // flag traffic must leave the array untouched
            do_op(2'h0, 13'h0000, 18'h00000, 2'h3);
            check(rd, 18'h15555);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_idle;
        t_lanes;
        t_flag;
        stop_test;
    end
endmodule // dpsc_port_ctrl_test
